// *** src/rsq_irq_arb.sv ***
// Purpose: interrupt latch and fixed priority arbiter
// Assumes: bit 0 is the highest priority source
// Notes:   a latched winner holds until serviced or mask clears
`timescale 1ns/1ns
module rsq_irq_arb #(
  parameter int unsigned N = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] pend,
  input  wire logic         boundary,
  input  wire logic         blocked,
  input  wire logic         served,
  input  wire logic         mask_clear,
  output logic              latched,
  output logic [2:0]        winner
);
  function automatic logic [2:0] pick(input logic [N-1:0] p);
    pick = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (p[i]) begin
        pick = 3'(i);
      end
    end
  endfunction

  wire logic grab = boundary && !blocked && (|pend) && !latched;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      latched <= 1'b0;
      winner  <= '0;
    end else if (grab) begin
      latched <= 1'b1;
      winner  <= pick(pend);
    end else if (served || mask_clear) begin
      latched <= 1'b0;
    end
  end
endmodule

// *** src/rsq_pkg.sv ***
// Purpose: shared constants and types for the reset and exception sequencer
// Assumes: one clock, clk_sys at 125 MHz, osc_ref_clock arrives as a sampled pin
// Notes:   counts are in reference clock cycles
package rsq_pkg;
  // ==========================================================
  // timing counts
  localparam int unsigned CNT_W          = 13;
  localparam logic [12:0] STAB_CYCLES    = 13'h1000; // 4096
  localparam logic [12:0] TAIL_CYCLES    = 13'h0040; // 64
  localparam logic [12:0] PIN_LOW_CYC    = 13'h0020; // 32
  localparam logic [12:0] INTERNAL_RESET_SIGNAL_EXTRA     = 13'h0020; // 32
  localparam logic [12:0] SHORT_WAKE     = 13'h0020; // 32
  localparam logic [6:0]  PIN_MIN_CYC    = 7'h43;    // 67
  localparam logic [12:0] SVC_CLR_MASK   = 13'h000f; // keeps bits 3..0
  // ==========================================================
  // register bus
  localparam logic [3:0]  ADDR_CAUSE     = 4'h1;
  localparam logic [3:0]  ADDR_WDOG_SVC  = 4'hf;
  localparam logic [3:0]  ADDR_CTRL      = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_EN    = 4'h3;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam int unsigned WDOG_W         = 4;
  // cause register bit positions
  localparam int unsigned CB_POR = 7;
  localparam int unsigned CB_PIN = 6;
  localparam int unsigned CB_WDG = 5;
  localparam int unsigned CB_OPC = 4;
  localparam int unsigned CB_ADR = 3;
  localparam int unsigned CB_UV  = 1;
  localparam int unsigned IRQ_N  = 8;
  localparam logic [7:0]  CTRL_RST_VAL = 8'h00;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_POR, SRC_UV, SRC_WDG, SRC_OPC, SRC_ADR
  } rsq_src_t;

  typedef struct packed {
    logic       instr_done;
    logic       opcode_fetch;
    logic       unmapped;
    logic       undefined_op;
    logic       halt_exec;
    logic       trap_exec;
    logic       mask_bit;
  } rsq_cpu_t;

  typedef struct packed {
    logic       take;
    logic       is_trap;
    logic [2:0] vector_sel;
    logic       set_mask;
    logic       push_pc_minus1;
  } rsq_exc_t;
endpackage

// *** src/rsq_sys_counter.sv ***
// Purpose: 13-bit system counter, prescaler for the watchdog
// Assumes: ref_fall is a one-cycle pulse on each falling reference edge
// Notes:   overflow pulses once per wrap
`timescale 1ns/1ns
module rsq_sys_counter #(
  parameter int unsigned W = 13
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         ref_fall,
  input  wire logic         clr_all,
  input  wire logic         clr_svc,
  output logic [W-1:0]      count,
  output logic              ovf
);
  wire logic [W-1:0] cnt_inc = count + {{(W-1){1'b0}}, 1'b1};
  wire logic         wrap    = ref_fall && (&count);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      ovf   <= 1'b0;
    end else begin
      ovf <= wrap;
      if (clr_all) begin
        count <= '0;
      end else if (clr_svc) begin
        count <= count & W'(rsq_pkg::SVC_CLR_MASK);
      end else if (ref_fall) begin
        count <= cnt_inc;
      end
    end
  end
endmodule

// *** src/rsq_top.sv ***
// Purpose: reset source handling, system counter and exception sequencing
// Assumes: all pins pass two flip-flops; cpu signals share clk_sys
// Notes:   counter advances on sampled falling reference edges
//
// Functional notes
// - power-on holds reset pin low 4096 ref cycles, releases core 64 later
// - power-on sets its cause flag and clears all others
// - power-on asserts internal reset, enables bus clock, gates cpu clocks 4096 cycles
// - watchdog overflow resets the device and sets its cause flag
// - every internal reset drives the reset pin low
// - service write clears watchdog and system counter bits 12..4
// - watchdog disabled only by high-voltage pin qualified logic
// - undefined instruction sets bad-opcode flag and resets
// - halt with halt-allow at zero is a bad opcode
// - unmapped opcode fetch sets bad-fetch flag and resets; data fetch does not
// - undervoltage sets its flag, pin low 4096, release 64 later
// - system counter is 13 bits, advancing on falling reference edge
// - counter overflow clocks the watchdog as prescaler
// - halt clears counter; wake delay 32 if short wake else 4096
// - pin reset leaves counter alone; counter free-runs after reset
// - interrupt entry stacks registers and sets the mask bit
// - interrupts latched and arbitrated; latched one holds until served or mask clears
// - hardware interrupts only at boundary with mask clear and enable set
// - highest priority first; pending ones served before main line resumes
// - entry does not stack index high; software saves it
// - trap ignores mask and stacks current pc
// - all resets share highest priority, above interrupts
// - internal reset: pin low 32 cycles then internal reset 32 more
// - pin cause flag set after 67 low cycles unless power-on or undervoltage
// - reading the cause register clears it
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
module rsq_top #(
  parameter int unsigned IRQ_N = rsq_pkg::IRQ_N,
  parameter logic [12:0] STAB  = rsq_pkg::STAB_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              osc_ref_clock,
  input  wire logic              power_on_pulse,
  input  wire logic              undervoltage_detector,
  input  wire logic              rst_pin_in,
  output logic                   rst_pin_out,
  output logic                   rst_pin_oe,
  input  wire logic              hv_rst_pin,
  input  wire logic              hv_irq_pin,
  input  wire logic              monitor_mode,
  input  wire logic              break_state,
  input  wire logic              halt_allow,
  input  wire logic              short_wake_select,
  input  wire rsq_pkg::rsq_cpu_t cpu,
  input  wire logic [IRQ_N-1:0]  irq_req,
  input  wire logic              served,
  output rsq_pkg::rsq_exc_t      exc,
  output logic                   internal_reset_signal,
  output logic                   bus_clock_source,
  output logic                   cpu_clk_en,
  output logic                   halted,
  input  wire logic [3:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic [7:0]             rdata
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] ref_s, pin_s, uv_s, por_s, hv_s, hvr_s;
  logic       ref_d;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ref_s <= '0;
      pin_s <= 2'h3;
      uv_s  <= '0;
      por_s <= '0;
      hv_s  <= '0;
      hvr_s <= '0;
      ref_d <= 1'b0;
    end else begin
      ref_s <= {ref_s[0], osc_ref_clock};
      pin_s <= {pin_s[0], rst_pin_in};
      uv_s  <= {uv_s[0], undervoltage_detector};
      por_s <= {por_s[0], power_on_pulse};
      hv_s  <= {hv_s[0], (hv_rst_pin || hv_irq_pin)};
      hvr_s <= {hvr_s[0], hv_rst_pin};
      ref_d <= ref_s[1];
    end
  end
  wire logic ref_fall = ref_d && !ref_s[1];
  wire logic pin_low  = !pin_s[1];
  wire logic hv_any   = hv_s[1];

  // ==========================================================
  // register file
  logic [7:0]       cause_r, cause_nxt;
  logic [IRQ_N-1:0] irq_en_r;
  logic [rsq_pkg::WDOG_W-1:0] wdog_r;
  logic             wdog_ovf;

  wire logic svc_wr   = wr_stb && (addr == rsq_pkg::ADDR_WDOG_SVC);
  wire logic en_wr    = wr_stb && (addr == rsq_pkg::ADDR_IRQ_EN);
  wire logic cause_rd = rd_stb && (addr == rsq_pkg::ADDR_CAUSE);

  // ==========================================================
  // reset source detection
  // in break the reset pin alone may also disable the watchdog; in monitor mode either pin does
  wire logic wdog_off   = (hv_any && monitor_mode) || (break_state && hvr_s[1]);
  wire logic halt_bad   = cpu.halt_exec && !halt_allow;
  wire logic opc_bad    = cpu.undefined_op || halt_bad;
  wire logic adr_bad    = cpu.unmapped && cpu.opcode_fetch;
  wire logic por_ev     = por_s[1];
  wire logic uv_ev      = uv_s[1];
  wire logic wdg_ev     = wdog_ovf && !wdog_off;

  typedef enum logic [2:0] {S_RUN, S_STAB, S_PINLOW, S_INTERNAL_RESET_SIGNAL, S_HALT, S_WAKE} rsq_state_t;
  rsq_state_t   st_r, st_nxt;
  logic [12:0]  tcnt_r, tcnt_nxt;
  logic [6:0]   pcnt_r;
  logic         long_src_r;
  logic         pin_set_r;

  // all reset sources are unarbitrated and preempt any exception
  wire logic long_ev  = por_ev || uv_ev;
  wire logic short_ev = wdg_ev || opc_bad || adr_bad;
  wire logic any_ev   = long_ev || short_ev;

  // ==========================================================
  // system counter and watchdog
  logic [12:0] scnt;
  logic        sovf;
  wire logic   halt_ok = cpu.halt_exec && halt_allow && (st_r == S_RUN);
  // pin reset does not touch the counter, internal resets clear it
  wire logic   cnt_clr = any_ev || halt_ok || (st_r == S_HALT);

  rsq_sys_counter #(.W(rsq_pkg::CNT_W)) u_cnt (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .ref_fall (ref_fall),
    .clr_all  (cnt_clr),
    .clr_svc  (svc_wr),
    .count    (scnt),
    .ovf      (sovf)
  );

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wdog_r   <= '0;
      wdog_ovf <= 1'b0;
    end else begin
      wdog_ovf <= sovf && (&wdog_r);
      if (svc_wr || internal_reset_signal) begin
        wdog_r <= '0;
      end else if (sovf) begin
        wdog_r <= wdog_r + 4'h1;
      end
    end
  end

  // ==========================================================
  // reset sequencer
  wire logic [12:0] tcnt_inc = tcnt_r + 13'h0001;
  wire logic        wake_ev  = (|(irq_req & irq_en_r)) || cpu.trap_exec;
  wire logic [12:0] wake_len = short_wake_select ? rsq_pkg::SHORT_WAKE : STAB;

  always_comb begin
    st_nxt   = st_r;
    tcnt_nxt = tcnt_r;
    if (any_ev) begin
      st_nxt   = long_ev ? S_STAB : S_PINLOW;
      tcnt_nxt = '0;
    end else begin
      case (st_r)
        S_RUN: begin
          if (halt_ok) begin
            st_nxt = S_HALT;
          end
        end
        S_STAB: begin
          if (ref_fall) begin
            tcnt_nxt = tcnt_inc;
          end
          if (tcnt_r == STAB) begin
            st_nxt   = S_INTERNAL_RESET_SIGNAL;
            tcnt_nxt = '0;
          end
        end
        S_PINLOW: begin
          if (ref_fall) begin
            tcnt_nxt = tcnt_inc;
          end
          if (tcnt_r == rsq_pkg::PIN_LOW_CYC) begin
            st_nxt   = S_INTERNAL_RESET_SIGNAL;
            tcnt_nxt = '0;
          end
        end
        S_INTERNAL_RESET_SIGNAL: begin
          if (ref_fall) begin
            tcnt_nxt = tcnt_inc;
          end
          // long sources wait the full 64, short ones the extra 32
          if (tcnt_r == (long_src_r ? rsq_pkg::TAIL_CYCLES : rsq_pkg::INTERNAL_RESET_SIGNAL_EXTRA)) begin
            st_nxt = S_RUN;
          end
        end
        S_HALT: begin
          if (wake_ev || pin_low) begin
            st_nxt   = S_WAKE;
            tcnt_nxt = '0;
          end
        end
        S_WAKE: begin
          if (ref_fall) begin
            tcnt_nxt = tcnt_inc;
          end
          if (tcnt_r == wake_len) begin
            st_nxt = S_RUN;
          end
        end
        default: st_nxt = S_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r       <= S_STAB;
      tcnt_r     <= '0;
      long_src_r <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      tcnt_r <= tcnt_nxt;
      if (any_ev) begin
        long_src_r <= long_ev;
      end else if (st_nxt == S_RUN) begin
        // a finished long sequence no longer masks the pin flag
        long_src_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pin reset qualification
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pcnt_r    <= '0;
      pin_set_r <= 1'b0;
    end else begin
      pin_set_r <= 1'b0;
      if (!pin_low || rst_pin_oe) begin
        pcnt_r <= '0;
      end else if (ref_fall && pcnt_r != rsq_pkg::PIN_MIN_CYC) begin
        pcnt_r <= pcnt_r + 7'h01;
        pin_set_r <= (pcnt_r + 7'h01) == rsq_pkg::PIN_MIN_CYC;
      end
    end
  end

  // ==========================================================
  // cause register: hardware set wins over the read clear
  always_comb begin
    cause_nxt = cause_rd ? 8'h00 : cause_r;
    if (por_ev) begin
      cause_nxt = 8'h00;
      cause_nxt[rsq_pkg::CB_POR] = 1'b1;
    end else begin
      if (uv_ev)  cause_nxt[rsq_pkg::CB_UV]  = 1'b1;
      if (wdg_ev) cause_nxt[rsq_pkg::CB_WDG] = 1'b1;
      if (opc_bad) cause_nxt[rsq_pkg::CB_OPC] = 1'b1;
      if (adr_bad) cause_nxt[rsq_pkg::CB_ADR] = 1'b1;
      if (pin_set_r && !long_src_r) cause_nxt[rsq_pkg::CB_PIN] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cause_r  <= 8'h80;
      irq_en_r <= '0;
    end else begin
      cause_r <= cause_nxt;
      if (en_wr) begin
        irq_en_r <= wdata[IRQ_N-1:0];
      end
    end
  end

  // ==========================================================
  // exception sequencing
  wire logic        in_run   = (st_r == S_RUN) && !any_ev;
  wire logic        boundary = in_run && cpu.instr_done;
  wire logic [IRQ_N-1:0] pend = irq_req & irq_en_r;
  logic             lat;
  logic [2:0]       win;
  logic             mask_d;
  logic             hw_done_r;
  wire logic        trap_take = boundary && cpu.trap_exec;
  // one entry per latched interrupt, the core masks itself after it
  wire logic        hw_take   = in_run && lat && !cpu.mask_bit && !hw_done_r && !trap_take;

  rsq_irq_arb #(.N(IRQ_N)) u_arb (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .pend       (pend),
    .boundary   (boundary),
    .blocked    (cpu.mask_bit),
    .served     (served),
    .mask_clear (mask_d && !cpu.mask_bit),
    .latched    (lat),
    .winner     (win)
  );

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mask_d    <= 1'b1;
      hw_done_r <= 1'b0;
      exc       <= '0;
    end else begin
      mask_d    <= cpu.mask_bit;
      hw_done_r <= lat && (hw_done_r || hw_take);
      exc       <= '0;
      if (trap_take) begin
        exc.take    <= 1'b1;
        exc.is_trap <= 1'b1;
        exc.set_mask <= 1'b1;
      end else if (hw_take) begin
        // index high is not part of the stacked frame
        exc.take           <= 1'b1;
        exc.vector_sel     <= win;
        exc.set_mask       <= 1'b1;
        exc.push_pc_minus1 <= 1'b1;
      end
    end
  end

  // ==========================================================
  // outputs
  wire logic [7:0] rd_data =
    (addr == rsq_pkg::ADDR_CAUSE)  ? cause_r :
    (addr == rsq_pkg::ADDR_IRQ_EN) ? 8'(irq_en_r) :
    (addr == rsq_pkg::ADDR_STATUS) ? {lat, win, halted, 3'(st_r)} : 8'h00;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rst_pin_oe            <= 1'b1;
      internal_reset_signal <= 1'b1;
      cpu_clk_en            <= 1'b0;
      halted                <= 1'b0;
      rdata                 <= '0;
    end else begin
      rst_pin_oe            <= (st_nxt == S_STAB) || (st_nxt == S_PINLOW);
      internal_reset_signal <= (st_nxt == S_STAB) || (st_nxt == S_PINLOW) || (st_nxt == S_INTERNAL_RESET_SIGNAL);
      cpu_clk_en            <= (st_nxt == S_RUN) || (st_nxt == S_INTERNAL_RESET_SIGNAL);
      halted                <= (st_nxt == S_HALT) || (st_nxt == S_WAKE);
      rdata                 <= rd_data;
    end
  end
  assign rst_pin_out      = 1'b0;
  assign bus_clock_source = 1'b1;
endmodule

// *** verification/rsq_pin_model.sv ***
// Purpose: far side model: reference oscillator and the shared reset pin
// Assumes: reference period of 64 ns, eight system clocks
// Notes:   the pin has a pull-up, so a released pin reads high
`timescale 1ns/1ns
module rsq_pin_model #(
  parameter int REF_HALF = 32
) (
  input  wire logic rst_pin_oe,
  input  wire logic rst_pin_out,
  input  wire logic ext_pull_low,
  output logic      osc_ref_clock,
  output logic      rst_pin_in
);
  // free-running oscillator, phase offset from the system clock on purpose
  initial begin
    osc_ref_clock = 1'b1;
    #3;
    forever #(REF_HALF) osc_ref_clock = ~osc_ref_clock;
  end
  // open-drain wire: any party pulling low wins over the pull-up
  assign rst_pin_in = ~((rst_pin_oe & ~rst_pin_out) | ext_pull_low);
endmodule

// *** verification/rsq_props.sv ***
// Purpose: port-level checks for the reset and exception sequencer
// Assumes: one clock domain; the checker sees only the top-level ports
// Notes:   latency windows leave room for the two-flop pin synchronisers
`timescale 1ns/1ns
module rsq_props (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              undervoltage_detector,
  input  wire logic              halt_allow,
  input  wire logic              rst_pin_out,
  input  wire logic              rst_pin_oe,
  input  wire rsq_pkg::rsq_cpu_t cpu,
  input  wire rsq_pkg::rsq_exc_t exc,
  input  wire logic              internal_reset_signal,
  input  wire logic              bus_clock_source,
  input  wire logic              cpu_clk_en,
  input  wire logic              halted
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // reset sources and the reset pin
  a_bus_clk_on:
    assert property (bus_clock_source == 1'b1) else $error("bus clock source inactive");
  a_pin_only_low:
    assert property (rst_pin_oe |-> rst_pin_out == 1'b0) else $error("reset pin driven high");
  a_cpu_clk_gated:
    assert property (rst_pin_oe |-> !cpu_clk_en) else $error("cpu clock runs while pin driven");
  a_internal_reset_signal_tail_holds:
    assert property ($fell(rst_pin_oe) |-> internal_reset_signal [*8]) else $error("internal reset ended with pin");
  a_uv_drives_pin:
    assert property ($rose(undervoltage_detector) |-> ##[1:8] rst_pin_oe) else $error("undervoltage not reset");
  a_opcode_resets:
    assert property (cpu.undefined_op && cpu_clk_en |-> ##[1:8] rst_pin_oe) else $error("bad opcode not reset");
  a_halt_refused:
    assert property (cpu.halt_exec && !halt_allow && cpu_clk_en |-> ##[1:8] rst_pin_oe)
    else $error("forbidden halt not reset");
  a_fetch_resets:
    assert property (cpu.opcode_fetch && cpu.unmapped && cpu_clk_en |-> ##[1:8] rst_pin_oe)
    else $error("unmapped opcode fetch not reset");
  // ==========================================================
  // exception entry
  a_trap_taken:
    assert property (cpu.instr_done && cpu.trap_exec && cpu_clk_en && !internal_reset_signal && !halted
                     |=> exc.take && exc.is_trap) else $error("trap not taken");
  a_trap_pc:
    assert property (exc.take |-> exc.push_pc_minus1 == !exc.is_trap) else $error("wrong stacked pc form");
  a_entry_masks:
    assert property (exc.take |-> exc.set_mask) else $error("entry left mask clear");
  a_hw_needs_clear:
    assert property (exc.take && !exc.is_trap |-> $past(cpu.mask_bit) == 1'b0) else $error("masked irq taken");
  a_reset_over_irq:
    assert property (internal_reset_signal |-> !exc.take) else $error("exception during reset");
endmodule

// *** verification/rsq_top_test.sv ***
// Purpose: self-checking bench for the reset and exception sequencer
// Assumes: reference period is eight system clocks; stabilisation count cut to 16
// Notes:   watchdog overflow needs about a million cycles, so it is only serviced
`timescale 1ns/1ns
bind rsq_top rsq_props rsq_props_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .undervoltage_detector(undervoltage_detector), .halt_allow(halt_allow),
  .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .cpu(cpu), .exc(exc),
  .internal_reset_signal(internal_reset_signal), .bus_clock_source(bus_clock_source),
  .cpu_clk_en(cpu_clk_en), .halted(halted));
module rsq_top_test;
  localparam logic [12:0] STAB = 13'h0010;
  localparam int          REFP = 8;
  logic              clk_sys = 1'b0, sys_rst = 1'b1, power_on_pulse = 1'b0, undervoltage_detector = 1'b0;
  logic              halt_allow = 1'b0, short_wake_select = 1'b0, served = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
  logic              ext_pull_low = 1'b0, rd_d = 1'b0, bad, osc_ref_clock, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic              internal_reset_signal, bus_clock_source, cpu_clk_en, halted;
  logic              hv_rst_pin = 1'b0, hv_irq_pin = 1'b0, monitor_mode = 1'b0, break_state = 1'b0;
  logic [3:0]        addr = 4'h0;
  logic [7:0]        wdata = 8'h00, irq_req = 8'h00, rdata, lf = 8'h0a;
  rsq_pkg::rsq_cpu_t cpu = '0;
  rsq_pkg::rsq_exc_t exc, exp_e, got_e;
  logic [7:0]        rd_q[$];
  rsq_pkg::rsq_exc_t exc_q[$];
  int                num_errors = 0, checks_done = 0;

  always #4 clk_sys = ~clk_sys;

  rsq_top #(.IRQ_N(8), .STAB(STAB)) rsq_top_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .osc_ref_clock(osc_ref_clock), .power_on_pulse(power_on_pulse),
    .undervoltage_detector(undervoltage_detector), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .hv_rst_pin(hv_rst_pin), .hv_irq_pin(hv_irq_pin), .monitor_mode(monitor_mode),
    .break_state(break_state),
    .halt_allow(halt_allow), .short_wake_select(short_wake_select), .cpu(cpu), .irq_req(irq_req),
    .served(served), .exc(exc), .internal_reset_signal(internal_reset_signal),
    .bus_clock_source(bus_clock_source), .cpu_clk_en(cpu_clk_en), .halted(halted), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  rsq_pin_model rsq_pin_model_inst (
    .rst_pin_oe(rst_pin_oe), .rst_pin_out(rst_pin_out), .ext_pull_low(ext_pull_low),
    .osc_ref_clock(osc_ref_clock), .rst_pin_in(rst_pin_in));

  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [2:0] lowest(input logic [6:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 6; k >= 0; k--) if (v[k]) r = k[2:0];
    return r;
  endfunction
  function automatic logic sig(input int sel);
    case (sel)
      0: return rst_pin_oe;
      1: return internal_reset_signal & ~rst_pin_oe;
      default: return halted;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    // idle edge so a following read never drives the strobe twice in one step
    @(posedge clk_sys);
  endtask
  task automatic pulse_cpu(input rsq_pkg::rsq_cpu_t p);
    cpu <= p;
    @(posedge clk_sys);
    cpu <= {6'h00, p[0]};
  endtask
  task automatic serve;
    cpu <= 7'h01;
    served <= 1'b1;
    irq_req <= 8'h00;
    tick(1);
    served <= 1'b0;
    cpu <= 7'h00;
    tick(2);
  endtask
  // waits for sig(sel) to rise, then times how long it stays high in system clocks
  task automatic span(input int sel, input int exp_ref);
    int n, w;
    n = 0;
    w = 0;
    while (sig(sel) !== 1'b1 && w < 2000) begin
      @(posedge clk_sys);
      w++;
    end
    while (sig(sel) === 1'b1 && n < 40000) begin
      @(posedge clk_sys);
      n++;
    end
    checks_done++;
    if (n < (exp_ref - 1) * REFP || n > (exp_ref + 1) * REFP) begin
      num_errors++;
      $display("mismatch span%0d expected %0d seen %0d", sel, exp_ref * REFP, n);
    end
  endtask
  task automatic settle;
    int w;
    w = 0;
    tick(8);
    while ((rst_pin_oe | internal_reset_signal) !== 1'b0 && w < 3000) begin
      tick(1);
      w++;
    end
    check("settle", 8'h00, {7'h00, rst_pin_oe | internal_reset_signal});
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // result watcher: oldest note against each result
  always @(posedge clk_sys) begin
    rd_d <= rd_stb;
    if (rd_d === 1'b1) check("rdata", rd_q.pop_front(), rdata);
    if (exc.take === 1'b1) begin
      exp_e = '0;
      if (exc_q.size() > 0) exp_e = exc_q.pop_front();
      got_e = exc;
      if (exp_e.is_trap) got_e.vector_sel = exp_e.vector_sel;
      check("exc", {1'b0, exp_e}, {1'b0, got_e});
    end
  end

  initial begin
    tick(40000);
    num_errors++;
    give_verdict();
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    span(0, int'(STAB));
    span(1, 64);
    reg_rd(rsq_pkg::ADDR_CAUSE, 8'h80);
    reg_rd(rsq_pkg::ADDR_CAUSE, 8'h00);
    reg_rd(4'h7, 8'h00);
    reg_wr(rsq_pkg::ADDR_WDOG_SVC, lf);
    for (int s = 0; s < 3; s++) begin
      pulse_cpu(s == 0 ? 7'h08 : s == 1 ? 7'h04 : 7'h30);
      span(0, 32);
      span(1, 32);
      reg_rd(rsq_pkg::ADDR_CAUSE, 8'h01 << (s == 2 ? rsq_pkg::CB_ADR : rsq_pkg::CB_OPC));
    end
    // unmapped data fetch must not reset
    pulse_cpu(7'h10);
    bad = 1'b0;
    repeat (24) begin
      @(posedge clk_sys);
      bad |= rst_pin_oe;
    end
    check("data_fetch", 8'h00, {7'h00, bad});
    undervoltage_detector <= 1'b1;
    tick(3);
    undervoltage_detector <= 1'b0;
    span(0, int'(STAB));
    span(1, 64);
    reg_rd(rsq_pkg::ADDR_CAUSE, 8'h01 << rsq_pkg::CB_UV);
    // a stale opcode flag must be wiped by power-on
    pulse_cpu(7'h08);
    span(0, 32);
    span(1, 32);
    power_on_pulse <= 1'b1;
    tick(3);
    power_on_pulse <= 1'b0;
    span(0, int'(STAB));
    span(1, 64);
    reg_rd(rsq_pkg::ADDR_CAUSE, 8'h80);
    ext_pull_low <= 1'b1;
    tick(80 * REFP);
    ext_pull_low <= 1'b0;
    settle();
    reg_rd(rsq_pkg::ADDR_CAUSE, 8'h01 << rsq_pkg::CB_PIN);
    reg_wr(rsq_pkg::ADDR_IRQ_EN, 8'h7f);
    reg_rd(rsq_pkg::ADDR_IRQ_EN, 8'h7f);
    for (int i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      irq_req <= (i == 0) ? 8'h80 : lf;
      {hv_rst_pin, hv_irq_pin, monitor_mode, break_state} <= lf[3:0];
      tick(2);
      if (irq_req[6:0] != 7'h00) exc_q.push_back({2'b10, lowest(irq_req[6:0]), 2'b11});
      pulse_cpu(7'h40);
      tick(6);
      serve();
    end
    irq_req <= 8'h01;
    cpu <= 7'h01;
    tick(2);
    pulse_cpu(7'h41);
    tick(6);
    exc_q.push_back(7'h62);
    pulse_cpu(7'h43);
    tick(6);
    serve();
    for (int w = 0; w < 2; w++) begin
      halt_allow <= 1'b1;
      short_wake_select <= (w == 0);
      pulse_cpu(7'h04);
      tick(8);
      check("halted", 8'h01, {7'h00, halted});
      exc_q.push_back(7'h4f);
      irq_req <= 8'h08;
      span(2, w == 0 ? 32 : int'(STAB));
      pulse_cpu(7'h40);
      tick(6);
      serve();
    end
    reg_wr(rsq_pkg::ADDR_WDOG_SVC, 8'h00);
    tick(4);
    check("pending", 8'h00, 8'(exc_q.size() + rd_q.size()));
    give_verdict();
  end
endmodule
